// File: shared/mbh_pkg.sv
// Purpose: shared constants for the register function handler link
// Assumes: byte-wide frames, crc-16 low byte first on the wire
// Notes:   both ends import this package
package mbh_pkg;
  localparam logic [7:0]  FC_READ       = 8'h03;
  localparam logic [7:0]  FC_WRITE      = 8'h06;
  localparam logic [7:0]  FC_DIAG       = 8'h08;
  localparam logic [7:0]  FC_EXC_FLAG   = 8'h80;
  localparam logic [15:0] SUB_ECHO      = 16'h0000;
  localparam logic [7:0]  EXC_FUNC      = 8'h01;
  localparam logic [7:0]  EXC_ADDR      = 8'h02;
  localparam logic [7:0]  EXC_DATA      = 8'h03;
  localparam logic [15:0] ADDR_LIMIT    = 16'h2000;
  localparam logic [15:0] MAX_COUNT     = 16'h0010;
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [15:0] CRC_POLY      = 16'ha001;
  localparam int          REG_W         = 16;
  localparam int          ADDR_W        = 13;
  localparam int          QUERY_LEN     = 8;
  localparam int          BUF_LEN       = 37;
  localparam logic [7:0]  SLAVE_ADDR    = 8'h01;
  localparam logic [7:0]  BCAST_ADDR    = 8'h00;

  typedef logic [7:0] mbh_byte_t;

  // one byte folded into a running crc-16, lsb first
  function automatic logic [15:0] mbh_crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
endpackage

// File: shared/mbh_link_if.sv
// Purpose: byte stream link between master and slave ends
// Assumes: one clock, valid/ready per direction, last marks frame end
// Notes:   no clocking block
`timescale 1ns/10ps
`default_nettype none
interface mbh_link_if;
  logic       q_valid;
  logic       q_ready;
  logic [7:0] q_data;
  logic       q_last;
  logic       r_valid;
  logic       r_ready;
  logic [7:0] r_data;
  logic       r_last;

  modport slave
  (
    input  q_valid, q_data, q_last, r_ready,
    output q_ready, r_valid, r_data, r_last
  );
  modport master
  (
    output q_valid, q_data, q_last, r_ready,
    input  q_ready, r_valid, r_data, r_last
  );
endinterface
`default_nettype wire

// File: rtl/mbh_slave.sv
// Purpose: slave end serving read, single write and diagnosis codes
// Assumes: query bytes arrive whole, crc already included in frame
// Notes:   register file lives inside; user side sees write commits
`timescale 1ns/10ps
`default_nettype none
module mbh_slave
  import mbh_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rstn,
  mbh_link_if.slave               link,
  output logic                    wr_strobe,
  output logic [ADDR_W-1:0]       wr_addr,
  output logic [REG_W-1:0]        wr_value,
  output logic                    crc_error
);
  import mbh_pkg::*;

  typedef enum {ST_RX, ST_EXEC, ST_SNAP, ST_TX} mbh_state_e;

  logic [REG_W-1:0] regs [2**ADDR_W];
  logic [7:0]       buf_b [BUF_LEN];
  mbh_state_e       state, next_state;
  logic [5:0]       idx, next_idx, len, next_len;
  logic [15:0]      crc, next_crc;
  logic             next_wr_strobe, next_crc_error;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [REG_W-1:0] next_wr_value;
  logic [4:0]       snap_i, next_snap_i;
  logic [7:0]       wb [BUF_LEN];
  logic             do_commit;
  // read window kept apart: reply data overwrites the query fields in place
  logic [ADDR_W-1:0] rd_base, next_rd_base;
  logic [4:0]       rd_cnt, next_rd_cnt;

  // address, code, byte count or exception code, crc low, crc high
  localparam logic [5:0] EXC_LEN    = 6'd5;
  localparam logic [5:0] RD_HDR_LEN = 6'd5;

  wire [15:0] q_addr  = {buf_b[2], buf_b[3]};
  wire [15:0] q_word  = {buf_b[4], buf_b[5]};
  wire [16:0] q_end   = {1'b0, q_addr} + {1'b0, q_word};

  assign link.q_ready = (state == ST_RX);
  assign link.r_valid = (state == ST_TX);
  assign link.r_data  = buf_b[idx];
  assign link.r_last  = (state == ST_TX) && (idx == len - 6'd1);

  always_comb
  begin
    next_state     = state;
    next_idx       = idx;
    next_len       = len;
    next_crc       = crc;
    next_wr_strobe = 1'b0;
    next_wr_addr   = wr_addr;
    next_wr_value  = wr_value;
    next_crc_error = 1'b0;
    next_snap_i    = snap_i;
    next_rd_base   = rd_base;
    next_rd_cnt    = rd_cnt;
    do_commit      = 1'b0;
    for (int i = 0; i < BUF_LEN; i++)
    begin
      wb[i] = buf_b[i];
    end
    unique case (state)
      ST_RX:
      begin
        if (link.q_valid)
        begin
          if (idx < 6'(BUF_LEN))
          begin
            wb[idx] = link.q_data;
          end
          next_crc = mbh_crc_byte(crc, link.q_data);
          next_idx = idx + 6'd1;
          if (link.q_last)
          begin
            next_len   = idx + 6'd1;
            next_idx   = '0;
            next_crc   = CRC_INIT;
            // residue of a good frame with its own crc appended is zero
            if (mbh_crc_byte(crc, link.q_data) != 16'h0000)
            begin
              next_crc_error = 1'b1;
            end
            else if (buf_b[0] == SLAVE_ADDR || buf_b[0] == BCAST_ADDR)
            begin
              next_state = ST_EXEC;
            end
          end
        end
      end
      ST_EXEC:
      begin
        next_len    = 6'(QUERY_LEN);
        next_state  = ST_TX;
        if (buf_b[1] == FC_READ)
        begin
          if (q_word == 16'h0000 || q_word > MAX_COUNT)
          begin
            wb[2] = EXC_DATA;
            next_len = EXC_LEN;
          end
          else if (q_end > {1'b0, ADDR_LIMIT})
          begin
            wb[2] = EXC_ADDR;
            next_len = EXC_LEN;
          end
          else
          begin
            next_state   = ST_SNAP;
            next_snap_i  = '0;
            next_rd_base = q_addr[ADDR_W-1:0];
            next_rd_cnt  = q_word[4:0];
            next_len     = RD_HDR_LEN + {q_word[4:0], 1'b0};
          end
        end
        else if (buf_b[1] == FC_WRITE)
        begin
          if (q_addr >= ADDR_LIMIT)
          begin
            wb[2] = EXC_ADDR;
            next_len = EXC_LEN;
          end
          else
          begin
            do_commit      = 1'b1;
            next_wr_strobe = 1'b1;
            next_wr_addr   = q_addr[ADDR_W-1:0];
            next_wr_value  = q_word;
          end
        end
        else if (buf_b[1] == FC_DIAG && q_addr == SUB_ECHO)
        begin
          next_len = 6'(QUERY_LEN);
        end
        else
        begin
          wb[2] = EXC_FUNC;
          next_len = EXC_LEN;
        end
        if (next_len == EXC_LEN)
        begin
          wb[1] = buf_b[1] | FC_EXC_FLAG;
        end
        if (next_state == ST_TX)
        begin
          next_idx = '0;
          next_crc = CRC_INIT;
        end
        if (buf_b[0] == BCAST_ADDR)
        begin
          next_state = ST_RX;
        end
      end
      ST_SNAP:
      begin
        // whole read copied in back-to-back cycles with no write between
        wb[2] = {2'b00, rd_cnt, 1'b0};
        wb[3 + 2 * snap_i] = regs[rd_base + ADDR_W'(snap_i)][15:8];
        wb[4 + 2 * snap_i] = regs[rd_base + ADDR_W'(snap_i)][7:0];
        next_snap_i = snap_i + 5'd1;
        if (snap_i == rd_cnt - 5'd1)
        begin
          next_state = ST_TX;
          next_idx   = '0;
          next_crc   = CRC_INIT;
        end
      end
      ST_TX:
      begin
        // crc regenerated on the fly; echo frames rebuild the same value
        if (link.r_ready)
        begin
          next_idx = idx + 6'd1;
          // folded only on accept, so a stalled byte is not counted twice
          if (idx < len - 6'd2)
          begin
            next_crc = mbh_crc_byte(crc, buf_b[idx]);
            if (idx == len - 6'd3)
            begin
              wb[idx+1] = next_crc[7:0];
              wb[idx+2] = next_crc[15:8];
            end
          end
          if (idx == len - 6'd1)
          begin
            next_state = ST_RX;
            next_idx   = '0;
            next_crc   = CRC_INIT;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state     <= ST_RX;
      idx       <= '0;
      len       <= '0;
      crc       <= CRC_INIT;
      wr_strobe <= 1'b0;
      wr_addr   <= '0;
      wr_value  <= '0;
      crc_error <= 1'b0;
      snap_i    <= '0;
      rd_base   <= '0;
      rd_cnt    <= '0;
    end
    else
    begin
      state     <= next_state;
      idx       <= next_idx;
      len       <= next_len;
      crc       <= next_crc;
      wr_strobe <= next_wr_strobe;
      wr_addr   <= next_wr_addr;
      wr_value  <= next_wr_value;
      crc_error <= next_crc_error;
      snap_i    <= next_snap_i;
      rd_base   <= next_rd_base;
      rd_cnt    <= next_rd_cnt;
    end
  end

  // frame buffer and register array carry no reset
  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < BUF_LEN; i++)
    begin
      buf_b[i] <= wb[i];
    end
    if (do_commit)
    begin
      regs[q_addr[ADDR_W-1:0]] <= q_word;
    end
  end
endmodule
`default_nettype wire

// File: rtl/mbh_master.sv
// Purpose: master end building queries and collecting responses
// Assumes: user issues one command at a time, waits for done
// Notes:   only the first three response bytes and the byte count are kept
`timescale 1ns/10ps
`default_nettype none
module mbh_master
  import mbh_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rstn,
  mbh_link_if.master              link,
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire logic [7:0]         cmd_func,
  input  wire logic [15:0]        cmd_word_a,
  input  wire logic [15:0]        cmd_word_b,
  output logic                    rsp_done,
  output logic [5:0]              rsp_len,
  output logic [7:0]              rsp_byte0,
  output logic [7:0]              rsp_byte1,
  output logic [7:0]              rsp_byte2,
  output logic                    rsp_crc_ok
);
  import mbh_pkg::*;

  typedef enum {MS_IDLE, MS_TX, MS_RX} mbh_mstate_e;

  mbh_mstate_e state, next_state;
  logic [7:0]  q [QUERY_LEN];
  logic [7:0]  next_q [QUERY_LEN];
  logic [2:0]  idx, next_idx;
  logic [15:0] crc, next_crc;
  logic [5:0]  next_rsp_len;
  logic [7:0]  next_b0, next_b1, next_b2;
  logic        next_done, next_ok;

  assign cmd_ready    = (state == MS_IDLE);
  assign link.q_valid = (state == MS_TX);
  assign link.q_data  = q[idx];
  assign link.q_last  = (state == MS_TX) && (idx == 3'(QUERY_LEN - 1));
  assign link.r_ready = (state == MS_RX);

  always_comb
  begin
    next_state   = state;
    next_idx     = idx;
    next_crc     = crc;
    next_rsp_len = rsp_len;
    next_b0      = rsp_byte0;
    next_b1      = rsp_byte1;
    next_b2      = rsp_byte2;
    next_done    = 1'b0;
    next_ok      = rsp_crc_ok;
    for (int i = 0; i < QUERY_LEN; i++)
    begin
      next_q[i] = q[i];
    end
    unique case (state)
      MS_IDLE:
      begin
        if (cmd_valid)
        begin
          // same field layout serves read, write and diagnosis
          next_q[0] = SLAVE_ADDR;
          next_q[1] = cmd_func;
          next_q[2] = cmd_word_a[15:8];
          next_q[3] = cmd_word_a[7:0];
          next_q[4] = cmd_word_b[15:8];
          next_q[5] = cmd_word_b[7:0];
          next_crc  = CRC_INIT;
          for (int i = 0; i < QUERY_LEN - 2; i++)
          begin
            next_crc = mbh_crc_byte(next_crc, next_q[i]);
          end
          next_q[6]  = next_crc[7:0];
          next_q[7]  = next_crc[15:8];
          next_crc   = CRC_INIT;
          next_idx   = '0;
          next_state = MS_TX;
        end
      end
      MS_TX:
      begin
        if (link.q_ready)
        begin
          next_idx = idx + 3'd1;
          if (link.q_last)
          begin
            next_state   = MS_RX;
            next_rsp_len = '0;
          end
        end
      end
      MS_RX:
      begin
        if (link.r_valid)
        begin
          next_crc     = mbh_crc_byte(crc, link.r_data);
          next_rsp_len = rsp_len + 6'd1;
          if (rsp_len == 6'd0) next_b0 = link.r_data;
          if (rsp_len == 6'd1) next_b1 = link.r_data;
          if (rsp_len == 6'd2) next_b2 = link.r_data;
          if (link.r_last)
          begin
            next_ok    = (next_crc == 16'h0000);
            next_done  = 1'b1;
            next_crc   = CRC_INIT;
            next_state = MS_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state      <= MS_IDLE;
      idx        <= '0;
      crc        <= CRC_INIT;
      rsp_len    <= '0;
      rsp_byte0  <= '0;
      rsp_byte1  <= '0;
      rsp_byte2  <= '0;
      rsp_done   <= 1'b0;
      rsp_crc_ok <= 1'b0;
      for (int i = 0; i < QUERY_LEN; i++)
      begin
        q[i] <= '0;
      end
    end
    else
    begin
      state      <= next_state;
      idx        <= next_idx;
      crc        <= next_crc;
      rsp_len    <= next_rsp_len;
      rsp_byte0  <= next_b0;
      rsp_byte1  <= next_b1;
      rsp_byte2  <= next_b2;
      rsp_done   <= next_done;
      rsp_crc_ok <= next_ok;
      for (int i = 0; i < QUERY_LEN; i++)
      begin
        q[i] <= next_q[i];
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/mbh_link_sva.sv
// Purpose: link checker for reply framing and echo rules
// Assumes: master never overlaps queries, slave at SLAVE_ADDR
// Notes:   query bytes kept so replies can be compared to them
`timescale 1ns/10ps
`default_nettype none
module mbh_link_sva
  import mbh_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       q_valid,
  input wire logic       q_ready,
  input wire logic [7:0] q_data,
  input wire logic       q_last,
  input wire logic       r_valid,
  input wire logic       r_ready,
  input wire logic [7:0] r_data,
  input wire logic       r_last
);
  logic [5:0] qi;
  logic [5:0] ri;
  logic [7:0] qb [8];
  logic [7:0] rfn;
  logic [7:0] rbc;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      qi <= '0;
      ri <= '0;
      rfn <= '0;
      rbc <= '0;
    end
    else
    begin
      if (q_valid && q_ready)
      begin
        qi <= q_last ? 6'h0 : qi + 6'h1;
        if (qi < 6'h8)
          qb[qi[2:0]] <= q_data;
      end
      if (r_valid && r_ready)
      begin
        ri <= r_last ? 6'h0 : ri + 6'h1;
        if (ri == 6'h1)
          rfn <= r_data;
        if (ri == 6'h2)
          rbc <= r_data;
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_reply_hold: assert property (r_valid && !r_ready |=> r_valid && $stable(r_data))
    else $error("reply byte changed before accept");
  a_reply_addr: assert property (r_valid && ri == 6'h0 |-> r_data == SLAVE_ADDR)
    else $error("reply address wrong");
  a_func_echo: assert property (r_valid && ri == 6'h1 |->
    r_data == qb[1] || r_data == (qb[1] | FC_EXC_FLAG))
    else $error("reply function code wrong");
  a_reply_soon: assert property (q_valid && q_ready && q_last |=> !r_valid ##[1:40] r_valid)
    else $error("reply late or early");
  a_echo_bytes: assert property (r_valid && ri >= 6'h2 && ri < 6'h8 &&
    (rfn == FC_WRITE || rfn == FC_DIAG) |-> r_data == qb[ri[2:0]])
    else $error("echo differs from query");
  a_read_count: assert property (r_valid && ri == 6'h2 && rfn == FC_READ |->
    r_data == {qb[5][6:0], 1'b0} && r_data <= 8'h20)
    else $error("read byte count wrong");
  a_read_len: assert property (r_valid && r_last && rfn == FC_READ |->
    ri == rbc[5:0] + 6'h4)
    else $error("read reply length wrong");
  a_exc_len: assert property (r_valid && rfn[7] && ri >= 6'h2 |-> (ri == 6'h4) == r_last)
    else $error("exception length wrong");
  a_diag_sub: assert property (r_valid && ri == 6'h1 && qb[1] == FC_DIAG &&
    {qb[2], qb[3]} != SUB_ECHO |-> r_data == (FC_DIAG | FC_EXC_FLAG))
    else $error("bad sub-function served");

  c_read: cover property (r_valid && r_last && rfn == FC_READ);
  c_write: cover property (r_valid && r_last && rfn == FC_WRITE);
  c_exc: cover property (r_valid && r_last && rfn[7]);
endmodule
`default_nettype wire

// File: testbench/modbus_register_function_handler_bench.sv
// Purpose: end-to-end bench, master and slave joined by the link
// Assumes: one command at a time, slave at SLAVE_ADDR
// Notes:   reply bytes captured off the link to check data order
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module modbus_register_function_handler_bench;
  import mbh_pkg::*;
  logic              core_clk;
  logic              rstn;
  logic              cmd_valid;
  logic              cmd_ready;
  logic [7:0]        cmd_func;
  logic [15:0]       cmd_word_a;
  logic [15:0]       cmd_word_b;
  logic              rsp_done;
  logic [5:0]        rsp_len;
  logic [7:0]        rsp_byte0;
  logic [7:0]        rsp_byte1;
  logic [7:0]        rsp_byte2;
  logic              rsp_crc_ok;
  logic              wr_strobe;
  logic [ADDR_W-1:0] wr_addr;
  logic [REG_W-1:0]  wr_value;
  logic              crc_error;
  logic [7:0]        rx [64];
  int                ri;
  int                error_cnt;
  int                tests_run;
  logic [47:0]       eq [$];
  logic [28:0]       wq [$];
  logic [47:0]       e;
  logic [15:0]       a;
  logic [15:0]       v;
  logic [15:0]       w;
  logic [15:0]       vals [16];
  logic [15:0]       dq [$];

  mbh_link_if lk();
  mbh_master u_mbh_master
  (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .link       (lk),
    .cmd_valid  (cmd_valid),
    .cmd_ready  (cmd_ready),
    .cmd_func   (cmd_func),
    .cmd_word_a (cmd_word_a),
    .cmd_word_b (cmd_word_b),
    .rsp_done   (rsp_done),
    .rsp_len    (rsp_len),
    .rsp_byte0  (rsp_byte0),
    .rsp_byte1  (rsp_byte1),
    .rsp_byte2  (rsp_byte2),
    .rsp_crc_ok (rsp_crc_ok)
  );
  mbh_slave u_mbh_slave
  (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .link      (lk),
    .wr_strobe (wr_strobe),
    .wr_addr   (wr_addr),
    .wr_value  (wr_value),
    .crc_error (crc_error)
  );
  mbh_link_sva u_mbh_link_sva
  (
    .core_clk (core_clk),
    .rstn     (rstn),
    .q_valid  (lk.q_valid),
    .q_ready  (lk.q_ready),
    .q_data   (lk.q_data),
    .q_last   (lk.q_last),
    .r_valid  (lk.r_valid),
    .r_ready  (lk.r_ready),
    .r_data   (lk.r_data),
    .r_last   (lk.r_last)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    $display("errors %0d compares %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // expectation: crc_ok, len, bytes 0..2, data-check flag, data word
  task automatic op(input logic [7:0] f, input logic [15:0] wa, input logic [15:0] wb,
                    input logic [47:0] x);
    eq.push_back(x);
    cmd_func <= f;
    cmd_word_a <= wa;
    cmd_word_b <= wb;
    cmd_valid <= 1'b1;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    @(posedge core_clk iff rsp_done);
    @(posedge core_clk);
  endtask

  task automatic exc(input logic [7:0] f, input logic [15:0] wa, input logic [15:0] wb,
                     input logic [7:0] c);
    op(f, wa, wb, {1'b1, 6'd5, SLAVE_ADDR, f | FC_EXC_FLAG, c, 17'h0});
  endtask

  always @(posedge core_clk)
  begin
    if (lk.r_valid && lk.r_ready)
    begin
      rx[ri] = lk.r_data;
      ri = lk.r_last ? 0 : ri + 1;
    end
  end

  always @(negedge core_clk)
  begin
    if (rsp_done === 1'b1)
    begin
      e = eq.pop_front();
      `CHK({rsp_crc_ok, rsp_len, rsp_byte0, rsp_byte1, rsp_byte2}, e[47:17])
      if (e[16])
        `CHK({rx[3], rx[4]}, e[15:0])
      for (int k = 0; dq.size() > 0; k++)
        `CHK({rx[3 + 2 * k], rx[4 + 2 * k]}, dq.pop_front())
    end
    if (wr_strobe === 1'b1)
      `CHK({wr_addr, wr_value}, wq.pop_front())
    if (crc_error !== 1'b0)
      `CHK(crc_error, 1'b0)
  end

  initial
  begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_func = 8'h00;
    cmd_word_a = 16'h0;
    cmd_word_b = 16'h0;
    ri = 0;
    error_cnt = 0;
    tests_run = 0;
    void'($urandom(32'ha838));
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 4; i++)
    begin
      // start kept low enough that a sixteen-register read stays in range
      a = 16'($urandom) & 16'h1fef;
      // whole read window written first: the register array has no reset
      for (int j = 0; j < 16; j++)
      begin
        w = a + 16'(j);
        v = 16'($urandom);
        vals[j] = v;
        wq.push_back({w[12:0], v});
        op(FC_WRITE, w, v, {1'b1, 6'd8, SLAVE_ADDR, FC_WRITE, w[15:8], 17'h0});
      end
      op(FC_READ, a, 16'h1, {1'b1, 6'd7, SLAVE_ADDR, FC_READ, 8'h02, 1'b1, vals[0]});
      for (int j = 0; j < 16; j++)
      begin
        dq.push_back(vals[j]);
      end
      op(FC_READ, a, 16'h10, {1'b1, 6'd37, SLAVE_ADDR, FC_READ, 8'h20, 1'b1, vals[0]});
      op(FC_DIAG, SUB_ECHO, v, {1'b1, 6'd8, SLAVE_ADDR, FC_DIAG, 8'h00, 1'b1, 8'h00,
         v[15:8]});
    end
    exc(FC_READ, 16'h0, 16'h0, EXC_DATA);
    exc(FC_READ, 16'h0, 16'h11, EXC_DATA);
    exc(FC_READ, 16'h1fff, 16'h2, EXC_ADDR);
    exc(FC_READ, 16'h2000, 16'h1, EXC_ADDR);
    exc(FC_WRITE, 16'h2000, 16'h1, EXC_ADDR);
    exc(FC_DIAG, 16'h1, 16'h0, EXC_FUNC);
    exc(8'h04, 16'h0, 16'h0, EXC_FUNC);
    `CHK(eq.size() + wq.size() + dq.size(), 0)
    tally_and_finish();
  end

  // about 80 commands of at most about 65 cycles each; generous margin
  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
